// >>> rtl/qdr_pkg.sv
package qdr_pkg;
	// Fixed upper address pattern
	localparam logic [4:0] QDR_ADDR_FIXED = 5'h13;
	// Master code pattern, upper five bits
	localparam logic [4:0] QDR_MCODE = 5'h01;
	// Readback byte filler values
	localparam logic [5:0] QDR_PD_FILL = 6'h3F;
	localparam logic [5:0] QDR_LO_FILL = 6'h00;
	// Register widths and reset values
	localparam int QDR_REG_W = 12;
	localparam int QDR_NCH = 4;
	localparam logic [11:0] QDR_REG_RST = 12'h000;
	// Control byte field positions
	localparam int QDR_CTL_PD = 0;
	localparam int QDR_CTL_SEL_LO = 1;
	localparam int QDR_CTL_SEL_HI = 2;
	// Bit counter values
	localparam logic [3:0] QDR_BIT_LAST = 4'h8;
	localparam logic [3:0] QDR_BIT_RST = 4'h0;
	localparam logic [1:0] QDR_IDX_RST = 2'h0;
	// Protocol states, one-hot
	typedef enum logic [6:0] {
		QDR_IDLE = 7'h01,
		QDR_ADDR = 7'h02,
		QDR_AACK = 7'h04,
		QDR_CTRL = 7'h08,
		QDR_CACK = 7'h10,
		QDR_TX = 7'h20,
		QDR_MACK = 7'h40
	} qdr_state_e;
endpackage

// >>> rtl/qdr_sync.sv
`timescale 1ns/100ps
// Three-stage pin synchroniser, change taken when stages two and three agree
module qdr_sync
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic pin_out
);
	import qdr_pkg::*;
	typedef struct packed
	{
		logic [2:0] stage;
		logic level;
	} qdr_sync_s;
	qdr_sync_s sync_reg;
	qdr_sync_s sync_next;
	// Shift and agree
	always_comb
	begin
		sync_next = sync_reg;
		sync_next.stage = {sync_reg.stage[1:0], pin_in};
		if (sync_reg.stage[2] == sync_reg.stage[1])
		begin
			sync_next.level = sync_reg.stage[2];
		end
	end
	// Idle bus reads high
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync_reg <= '{stage: 3'h7, level: 1'b1};
		end
		else if (clk_en)
		begin
			sync_reg <= sync_next;
		end
	end
	assign pin_out = sync_reg.level;
endmodule // qdr_sync

// >>> rtl/qdr_readback.sv
`timescale 1ns/100ps
// Contract
// - Acknowledge write-direction address byte
// - Acknowledge control byte, latch select and flag
// - Read address must match 10011 and selects
// - After read ack, send bytes MSB first
// - Channel chosen by latest select bits
// - Byte count follows power-down flag
// - Flag clear: high then low byte
// - Flag set: power-down, high, low byte
// - Power-down byte: mode bits, then ones
// - High byte holds data bits nine to two
// - Low byte: bits one, zero, don't-care
// - Master code is never acknowledged
// - High-speed uses the same sequence
// - Control byte field layout
// - Per-channel twelve-bit temporary and converter registers
// - Converter registers clear at power-up
module qdr_readback
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_select_hi,
	input wire logic addr_select_lo,
	input wire logic [3:0] reg_wr,
	input wire logic [11:0] reg_wdata,
	output logic power_down_flag,
	output logic [1:0] chan_sel,
	output logic busy
);
	import qdr_pkg::*;
	typedef struct packed
	{
		logic [1:0] rst_sync;
		logic scl_d;
		logic sda_d;
		qdr_state_e state;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rd;
		logic [1:0] sel;
		logic pdf;
		logic [1:0] idx;
		logic drive;
		logic active; // Registered copy of not-idle
		logic [QDR_NCH*QDR_REG_W-1:0] temp_regs;
		logic [QDR_NCH*QDR_REG_W-1:0] conv_regs;
	} qdr_rb_s;
	qdr_rb_s s_reg;
	qdr_rb_s s_next;
	logic rst_n; // Released reset copy
	logic scl_s; // Synchronised clock line
	logic sda_s; // Synchronised data line
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rx_byte; // Byte with newest bit
	logic addr_hit; // Address match ignoring direction
	logic [QDR_REG_W-1:0] sel_reg; // Selected converter register
	logic [7:0] tx_byte; // Next byte to transmit
	logic last_byte;
	assign rst_n = s_reg.rst_sync[1];
	qdr_sync u_scl (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(scl_in), .pin_out(scl_s));
	qdr_sync u_sda (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .pin_in(sda_in), .pin_out(sda_s));
	// Edge and condition detection
	assign scl_rise = scl_s & ~s_reg.scl_d;
	assign scl_fall = ~scl_s & s_reg.scl_d;
	assign start_cond = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
	assign stop_cond = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
	assign rx_byte = {s_reg.shift[6:0], sda_s};
	assign addr_hit = (rx_byte[7:3] == QDR_ADDR_FIXED) && (rx_byte[2] == addr_select_hi)
		&& (rx_byte[1] == addr_select_lo);
	assign sel_reg = s_reg.conv_regs[s_reg.sel*QDR_REG_W +: QDR_REG_W];
	assign last_byte = (s_reg.idx == 2'h2) || (!s_reg.pdf && s_reg.idx == 2'h1);
	// Byte selection by position in the readback
	always_comb
	begin
		if (s_reg.pdf && s_reg.idx == 2'h0)
		begin
			tx_byte = {sel_reg[11:10], QDR_PD_FILL};
		end
		else if (last_byte)
		begin
			tx_byte = {sel_reg[1:0], QDR_LO_FILL};
		end
		else
		begin
			tx_byte = sel_reg[9:2];
		end
	end
	// Next-state logic
	always_comb
	begin
		s_next = s_reg;
		s_next.rst_sync = {s_reg.rst_sync[0], 1'b1};
		s_next.scl_d = scl_s;
		s_next.sda_d = sda_s;
		// Register loads from the write path
		for (int i = 0; i < QDR_NCH; i++)
		begin
			if (reg_wr[i])
			begin
				s_next.temp_regs[i*QDR_REG_W +: QDR_REG_W] = reg_wdata;
				s_next.conv_regs[i*QDR_REG_W +: QDR_REG_W] = reg_wdata;
			end
		end
		if (start_cond)
		begin
			// Start or repeated start always restarts addressing
			s_next.state = QDR_ADDR;
			s_next.bitcnt = QDR_BIT_RST;
			s_next.drive = 1'b0;
		end
		else if (stop_cond)
		begin
			s_next.state = QDR_IDLE;
			s_next.drive = 1'b0;
		end
		else
		begin
			case (s_reg.state)
				QDR_IDLE:
				begin
					s_next.drive = 1'b0;
				end
				QDR_ADDR, QDR_CTRL:
				begin
					if (scl_rise)
					begin
						s_next.shift = rx_byte;
						s_next.bitcnt = s_reg.bitcnt + 4'h1;
					end
					else if (scl_fall && s_reg.bitcnt == QDR_BIT_LAST)
					begin
						s_next.bitcnt = QDR_BIT_RST;
						if (s_reg.state == QDR_ADDR)
						begin
							// Master code falls through here unmatched
							if (s_reg.shift[7:3] == QDR_ADDR_FIXED && s_reg.shift[2] == addr_select_hi
								&& s_reg.shift[1] == addr_select_lo)
							begin
								s_next.rd = s_reg.shift[0];
								s_next.state = QDR_AACK;
								s_next.drive = 1'b1;
							end
							else
							begin
								s_next.state = QDR_IDLE;
							end
						end
						else
						begin
							s_next.sel = s_reg.shift[QDR_CTL_SEL_HI:QDR_CTL_SEL_LO];
							s_next.pdf = s_reg.shift[QDR_CTL_PD];
							s_next.state = QDR_CACK;
							s_next.drive = 1'b1;
						end
					end
				end
				QDR_AACK, QDR_CACK:
				begin
					if (scl_fall)
					begin
						if (s_reg.state == QDR_AACK && s_reg.rd)
						begin
							// Read direction: begin transmit from first byte
							s_next.state = QDR_TX;
							s_next.idx = QDR_IDX_RST;
							s_next.shift = (s_reg.pdf) ? {sel_reg[11:10], QDR_PD_FILL} : sel_reg[9:2];
							s_next.drive = ~((s_reg.pdf) ? sel_reg[11] : sel_reg[9]);
							s_next.bitcnt = QDR_BIT_RST;
						end
						else if (s_reg.state == QDR_AACK)
						begin
							s_next.state = QDR_CTRL;
							s_next.drive = 1'b0;
						end
						else
						begin
							// Further bytes belong to the write path
							s_next.state = QDR_IDLE;
							s_next.drive = 1'b0;
						end
					end
				end
				QDR_TX:
				begin
					if (scl_rise)
					begin
						s_next.bitcnt = s_reg.bitcnt + 4'h1;
					end
					else if (scl_fall)
					begin
						if (s_reg.bitcnt == QDR_BIT_LAST)
						begin
							s_next.state = QDR_MACK;
							s_next.drive = 1'b0;
						end
						else
						begin
							s_next.shift = {s_reg.shift[6:0], 1'b1};
							s_next.drive = ~s_reg.shift[6];
						end
					end
				end
				QDR_MACK:
				begin
					if (scl_rise)
					begin
						if (sda_s || last_byte)
						begin
							s_next.state = QDR_IDLE;
						end
						else
						begin
							s_next.idx = s_reg.idx + 2'h1;
						end
					end
					else if (scl_fall)
					begin
						s_next.state = QDR_TX;
						s_next.bitcnt = QDR_BIT_RST;
						s_next.shift = tx_byte;
						s_next.drive = ~tx_byte[7];
					end
				end
				default:
				begin
					s_next.state = QDR_IDLE;
					s_next.drive = 1'b0;
				end
			endcase
		end
		// Hold the machine idle until the released reset copy is high
		if (!rst_n)
		begin
			s_next.state = QDR_IDLE;
			s_next.drive = 1'b0;
		end
		// Busy flag taken from the next state so the port is a flop
		s_next.active = (s_next.state != QDR_IDLE);
	end
	// State register, converter registers cleared at reset
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_reg <= '0;
			s_reg.state <= QDR_IDLE;
			s_reg.scl_d <= 1'b1;
			s_reg.sda_d <= 1'b1;
			s_reg.conv_regs <= {QDR_NCH{QDR_REG_RST}};
			s_reg.temp_regs <= {QDR_NCH{QDR_REG_RST}};
		end
		else if (clk_en)
		begin
			s_reg <= s_next;
		end
	end
	// Open-drain drive: output low, enable when pulling
	assign sda_out = 1'b0;
	assign sda_oe = s_reg.drive;
	assign power_down_flag = s_reg.pdf;
	assign chan_sel = s_reg.sel;
	assign busy = s_reg.active;
endmodule // qdr_readback

// >>> bench/qdr_readback_props.sv
`timescale 1ns/100ps
// Port checks of the readback slave
module qdr_readback_props
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [1:0] chan_sel,
	input wire logic busy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_odrain_low: assert property (sda_out == 1'b0) else $error("drive value");
	chk_reset_quiet: assert property ($rose(arst_n) |-> !busy && !sda_oe) else $error("reset");
	chk_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in) else $error("drive edge");
	chk_free_scl_low: assert property ($fell(sda_oe) |-> !scl_in) else $error("release edge");
	chk_hold_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe)) else $error("hold");
	chk_busy_drive: assert property (sda_oe |-> busy) else $error("idle drive");
	chk_addr_quiet: assert property ($rose(busy) |-> !sda_oe [*8]) else $error("early ack");
	chk_sel_steady: assert property ($changed(chan_sel) |-> busy) else $error("select");
endmodule // qdr_readback_props

// >>> bench/qdr_master.sv
`timescale 1ns/100ps
// Bus master model; open-drain data, idle released
module qdr_master
(
	input wire logic core_clk,
	input wire logic sda,
	output logic scl = 1'b1,
	output logic sda_low = 1'b0
);
	// Wait n cycles, move just after the edge
	task t(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// Start, or repeated start from clock low
	task start();
		sda_low = 1'b0;
		t(8);
		scl = 1'b1;
		t(8);
		sda_low = 1'b1;
		t(8);
		scl = 1'b0;
		t(8);
	endtask
	// Stop condition
	task stop();
		sda_low = 1'b1;
		t(8);
		scl = 1'b1;
		t(8);
		sda_low = 1'b0;
		t(8);
	endtask
	// Nine clocks MSB first, last is the ack slot
	task xb(input logic [8:0] w, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low = !w[i];
			t(4);
			scl = 1'b1;
			t(4);
			r[i] = sda;
			t(4);
			scl = 1'b0;
			t(4);
		end
	endtask
endmodule // qdr_master

// >>> bench/qdr_readback_bench.sv
`timescale 1ns/100ps
// Self-checking bench for the readback slave
module qdr_readback_bench;
	import qdr_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [3:0] reg_wr = 4'h0;
	logic [11:0] reg_wdata = 12'h000;
	logic sda_oe, sda_out, scl, sda_low, power_down_flag, busy;
	logic [1:0] chan_sel;
	logic [8:0] r;
	logic [11:0] model [4];
	logic [31:0] seed = 32'h43F12768;
	int bad_count = 0;
	int n_compared = 0;
	// Pulled-up data wire
	wire sda = !sda_low && (sda_oe ? sda_out : 1'b1);
	always #5 core_clk = ~core_clk;
	qdr_readback uut(.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_select_hi(1'b1), .addr_select_lo(1'b0), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .power_down_flag(power_down_flag), .chan_sel(chan_sel), .busy(busy));
	qdr_master u_m(.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Readback byte k: power-down, high, low
	function logic [7:0] eb(input logic [11:0] v, input int k);
		return (k == 0) ? {v[11:10], 6'h3F} : (k == 1) ? v[9:2] : {v[1:0], 6'h00};
	endfunction
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			bad_count++;
			$display("Error %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task conclude();
		$display("compared %0d bad %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Random word into one channel
	task wr(input int ch);
		seed = lfsr(seed);
		reg_wdata = seed[11:0];
		reg_wr = 4'h1 << ch;
		model[ch] = seed[11:0];
		@(posedge core_clk);
		#1;
		reg_wr = 4'h0;
		// Let an edge pass before the next strobe
		@(posedge core_clk);
		#1;
	endtask
	// Address, control, readdress, then the bytes
	task rd(input logic [1:0] ch, input logic pd, input logic early);
		int n;
		n = pd ? 3 : 2;
		u_m.start();
		u_m.xb({QDR_ADDR_FIXED, 2'b10, 2'b01}, r);
		chk({7'h00, r[0]}, 8'h00);
		u_m.xb({5'h00, ch, pd, 1'b1}, r);
		chk({7'h00, r[0]}, 8'h00);
		chk({5'h00, chan_sel, power_down_flag}, {5'h00, ch, pd});
		u_m.start();
		u_m.xb({QDR_ADDR_FIXED, 2'b10, 2'b11}, r);
		chk({7'h00, r[0]}, 8'h00);
		for (int k = 0; k < n; k++)
		begin
			u_m.xb({8'hFF, early || k == n - 1}, r);
			chk(r[8:1], eb(model[ch], pd ? k : k + 1));
			if (early)
				break;
		end
		u_m.stop();
		chk({7'h00, busy}, 8'h00);
	endtask
	initial
	begin
		repeat (3) @(posedge core_clk);
		#1;
		arst_n = 1'b1;
		repeat (10) @(posedge core_clk);
		#1;
		for (int c = 0; c < 4; c++)
			model[c] = 12'h000;
		rd(2'h2, 1'b1, 1'b0);
		for (int i = 0; i < 8; i++)
		begin
			for (int c = 0; c < 4; c++)
				wr(c);
			rd(2'(i), i[2], 1'b0);
		end
		// Strobe while frozen must be lost
		clk_en = 1'b0;
		seed = lfsr(seed);
		reg_wdata = seed[11:0];
		reg_wr = 4'hF;
		@(posedge core_clk);
		#1;
		reg_wr = 4'h0;
		clk_en = 1'b1;
		@(posedge core_clk);
		#1;
		rd(2'h0, 1'b1, 1'b0);
		rd(2'h1, 1'b1, 1'b1);
		u_m.start();
		u_m.xb({QDR_ADDR_FIXED, 2'b01, 2'b01}, r);
		chk({7'h00, r[0]}, 8'h01);
		u_m.start();
		u_m.xb({QDR_MCODE, 3'h5, 1'b1}, r);
		chk({7'h00, r[0]}, 8'h01);
		rd(2'h3, 1'b1, 1'b0);
		conclude();
	end
	// Watchdog
	initial
	begin
		repeat (60000) @(posedge core_clk);
		bad_count++;
		conclude();
	end
endmodule // qdr_readback_bench
bind qdr_readback qdr_readback_props u_props(.core_clk(core_clk), .arst_n(arst_n), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .chan_sel(chan_sel), .busy(busy));
